/* adc_route_map.vh */
// Register offsets, field positions and reset values for the ADC route block
`ifndef ADC_ROUTE_MAP_VH
`define ADC_ROUTE_MAP_VH
// Word indices; byte address is four times the index, page 1 adds 0x400
`define MIC_BIAS_CONTROL_IDX      8'h33
`define CM_HOLD_FIRST_IDX         8'h34
`define CM_HOLD_LAST_IDX          8'h39
`define BLOCK_SELECT_IDX          8'h3D
`define ROUTE_LEFT_IDX            8'h40
`define ROUTE_RIGHT_IDX           8'h41
`define BLOCK_INFO_IDX            8'h42
`define ROUTE_STATUS_IDX          8'h43
`define OSR_IDX                   8'h44
// Reset values
`define MIC_BIAS_RESET            2'h3
`define CM_HOLD_RESET             2'h0
`define BLOCK_SELECT_RESET        5'h01
`define ROUTE_RESET               5'h00
`define OSR_RESET                 8'h80
// Mic bias field codes
`define MIC_BIAS_2V0              2'h0
`define MIC_BIAS_2V5              2'h1
`define MIC_BIAS_SUPPLY           2'h2
`define MIC_BIAS_OFF              2'h3
// Route register fields
`define ROUTE_SE_P_BIT            0
`define ROUTE_SE_M_BIT            1
`define ROUTE_DIFF_OWN_BIT        2
`define ROUTE_DIFF_CROSS_BIT      3
// Block info fields
`define FILTER_A                  2'h0
`define FILTER_B                  2'h1
`define FILTER_C                  2'h2
`define STAGE_NONE                2'h0
`define STAGE_BIQUAD              2'h1
`define STAGE_FIR                 2'h2
`endif

/* adc_input_route_and_block_select.v */
// APB register file for ADC input routing, bias and processing block choice
// What this block does
// - Same input allowed on both channel amplifiers
// - Unselected inputs float after reset
// - Per-input common-mode hold controls, software clears
// - Mic bias: 2 V, 2.5 V, supply, off
// - Three decimation filter types selectable
// - Block select register picks filter and resources
// - Reset selects block one, stereo, filter A
// - Every block has programmable first-order IIR
// - Blocks 1-6: filter A, OSR 128/64
// - Blocks 7-12: filter B, OSR 64
`timescale 1ns/1ps
`include "adc_route_map.vh"
// Register map, byte addresses
//   Page 1 sits at 0x400 plus four times the location index:
//     0x4CC  microphone bias mode, bits 1:0
//     0x4D0  common-mode hold, input 0, bit 0 enables
//     0x4D4  common-mode hold, input 1
//     0x4D8  common-mode hold, input 2
//     0x4DC  common-mode hold, input 3
//     0x4E0  common-mode hold, input 4
//     0x4E4  common-mode hold, input 5
//   Page 0 sits at four times the location index:
//     0x0F4  processing block number, bits 4:0, reset 1
//     0x100  left amplifier switches
//     0x104  right amplifier switches
//     0x108  decoded block info, read only
//     0x10C  route status, read only
//     0x110  oversampling ratio mirror, reset 0x80
//   Page sits on address bit 10 so that page 0 words above
//   index 0x3F keep clear of it; bits 9 and 11 must be zero.
//
// Switch word layout, both amplifiers
//   bit 0  single-ended positive input
//   bit 1  single-ended negative input
//   bit 2  own differential pair
//   bit 3  cross differential pair
//   bit 4  spare, stored and read back only
//
// Bus timing
//   Setup cycle is registered; pready rises for the access
//   cycle that follows, so every transfer takes two cycles.
//   Writes land at the end of the access cycle and the
//   outputs follow one clock later.
//   Unmapped or misaligned words answer with pslverr, write
//   nothing and read zero.
//   Writes to the two read-only words are dropped quietly.
//
// Hazards
//   A route that mixes differential and single-ended use of one
//   pair is held off the switches until software clears it,
//   because the amplifier input would otherwise be loaded twice.
//   The common-mode hold of an input routed single-ended is forced off, whatever
//   its register says, since the weak hold would bleed into the
//   recorded signal.
//   Both amplifiers may take the same input at once; only the
//   mixed-mode case above is refused.
//   Status flags are levels, recomputed each clock, never sticky,
//   so there is no set-versus-clear race to resolve.
//
// Limitations
//   The oversampling ratio is only mirrored here to flag a
//   mismatch; the clock tree owning the real ratio sits elsewhere.
//   An illegal block number falls back to block one resources
//   so the filter path is never left undefined.
module adc_input_route_and_block_select #(
  parameter NUM_INPUTS = 6
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg  [1:0]  microphone_bias_output,
  output reg  [5:0]  common_mode_hold_en,
  output reg  [3:0]  left_switch_en,
  output reg  [3:0]  right_switch_en,
  output reg  [1:0]  filter_type,
  output reg  [1:0]  extra_stage,
  output reg         stereo_mode,
  output reg         route_conflict,
  output reg         osr_mismatch
);

  // Register storage
  reg [1:0]  mic_bias_reg;                // Bias mode code
  reg [1:0]  cm_hold_reg [0:5];           // Per-input hold enable, bit0 used
  reg [4:0]  block_sel_reg;               // Processing block number 1..18
  reg [4:0]  route_left_reg;              // Left amplifier switch set
  reg [4:0]  route_right_reg;             // Right amplifier switch set
  reg [7:0]  osr_reg;                     // Oversampling ratio mirror
  reg [7:0]  word_addr;                   // Decoded word index
  reg        addr_ok;                     // Aligned, bits 9 and 11 clear
  reg        page_one;                    // Page select from address bit 10
  reg [31:0] rd_value;                    // Read mux result
  reg [1:0]  dec_filter;                  // Decoded filter type
  reg [1:0]  dec_stage;                   // Decoded extra stage
  reg        dec_stereo;                  // Decoded channel use
  reg        dec_valid;                   // Block number legal
  reg        dec_osr_ok;                  // Ratio fits block
  reg        conflict_now;                // Pair mode mismatch
  reg [4:0]  rel;                         // Index inside group of six
  integer    i;                           // Read mux loop index
  integer    j;                           // Write loop index
  integer    k;                           // Output loop index

  // Address decode; page on bit 10, bits 9 and 11 must be clear
  always @* begin
    // Word index within the page
    word_addr = {1'b0, paddr[8:2]};
    // Page select
    page_one  = paddr[10];
    // Aligned and inside the decoded window
    addr_ok   = (paddr[1:0] == 2'h0) && !paddr[9] && !paddr[11];
  end

  // Decode processing block into resources
  always @* begin
    dec_valid  = (block_sel_reg >= 5'd1) && (block_sel_reg <= 5'd18);
    dec_filter = `FILTER_A;
    dec_stage  = `STAGE_NONE;
    dec_stereo = 1'b1;
    dec_osr_ok = 1'b0;
    rel        = 5'd0;
    if (block_sel_reg <= 5'd6) begin
      rel        = block_sel_reg - 5'd1;
      dec_filter = `FILTER_A;
      dec_osr_ok = (osr_reg == 8'h80) || (osr_reg == 8'h40);
    end else if (block_sel_reg <= 5'd12) begin
      rel        = block_sel_reg - 5'd7;
      dec_filter = `FILTER_B;
      dec_osr_ok = (osr_reg == 8'h40);
    end else begin
      rel        = block_sel_reg - 5'd13;
      dec_filter = `FILTER_C;
      dec_osr_ok = (osr_reg == 8'h20);
    end
    // Pairs share resources; first half stereo
    case (rel)
      5'd0, 5'd3: dec_stage = `STAGE_NONE;
      5'd1, 5'd4: dec_stage = `STAGE_BIQUAD;
      5'd2, 5'd5: dec_stage = `STAGE_FIR;
      default:    dec_stage = `STAGE_NONE;
    endcase
    dec_stereo = (rel < 5'd3);
    // Filter C group: only blocks 14 and 15 are stereo
    if (block_sel_reg >= 5'd13) begin
      dec_stereo = (block_sel_reg == 5'd14) || (block_sel_reg == 5'd15);
    end
  end

  // Flag a pair used differential and single-ended at once
  always @* begin
    conflict_now =
      ((route_left_reg[`ROUTE_DIFF_OWN_BIT] || route_right_reg[`ROUTE_DIFF_CROSS_BIT]) &&
       (route_left_reg[`ROUTE_SE_P_BIT] || route_left_reg[`ROUTE_SE_M_BIT])) ||
      ((route_right_reg[`ROUTE_DIFF_OWN_BIT] || route_left_reg[`ROUTE_DIFF_CROSS_BIT]) &&
       (route_right_reg[`ROUTE_SE_P_BIT] || route_right_reg[`ROUTE_SE_M_BIT]));
  end

  // Read mux; unmapped words read zero, the error comes from the handshake
  always @* begin
    // Default zero keeps unused upper bits clean
    rd_value = 32'h0000_0000;
    if (page_one) begin
      // Bias mode word
      if (word_addr == `MIC_BIAS_CONTROL_IDX) begin
        rd_value[1:0] = mic_bias_reg;
      end
      // Six hold words in a row
      for (i = 0; i < 6; i = i + 1) begin
        if (word_addr == (`CM_HOLD_FIRST_IDX + i[7:0])) begin
          rd_value[1:0] = cm_hold_reg[i];
        end
      end
    end else begin
      // Page 0 words
      case (word_addr)
        `BLOCK_SELECT_IDX: rd_value[4:0] = block_sel_reg;
        `ROUTE_LEFT_IDX:   rd_value[4:0] = route_left_reg;
        `ROUTE_RIGHT_IDX:  rd_value[4:0] = route_right_reg;
        `BLOCK_INFO_IDX:   rd_value[6:0] = {dec_valid, dec_stereo, dec_stage, 1'b0, dec_filter};
        `ROUTE_STATUS_IDX: rd_value[1:0] = {dec_valid && !dec_osr_ok, conflict_now};
        `OSR_IDX:          rd_value[7:0] = osr_reg;
        default:           rd_value = 32'h0000_0000;
      endcase
    end
  end

  // Mapped check for the error answer
  wire in_page1 = page_one && (word_addr == `MIC_BIAS_CONTROL_IDX ||
                  (word_addr >= `CM_HOLD_FIRST_IDX && word_addr <= `CM_HOLD_LAST_IDX));
  wire in_page0 = !page_one && (word_addr == `BLOCK_SELECT_IDX ||
                  (word_addr >= `ROUTE_LEFT_IDX && word_addr <= `OSR_IDX));
  wire mapped   = addr_ok && (in_page1 || in_page0);
  wire ro_word  = !page_one && (word_addr == `BLOCK_INFO_IDX || word_addr == `ROUTE_STATUS_IDX);
  wire setup    = psel && !penable;
  wire access   = psel && penable && pready;
  wire do_write = access && pwrite && mapped && !ro_word;

  // APB handshake: no wait state, answer in first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      if (setup && !pwrite) begin
        prdata <= mapped ? rd_value : 32'h0000_0000;
      end
    end
  end

  // Register writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mic_bias_reg    <= `MIC_BIAS_RESET;
      block_sel_reg   <= `BLOCK_SELECT_RESET;
      // No input selected, no hold: high impedance
      route_left_reg  <= `ROUTE_RESET;
      route_right_reg <= `ROUTE_RESET;
      osr_reg         <= `OSR_RESET;
      for (i = 0; i < 6; i = i + 1) begin
        cm_hold_reg[i] <= `CM_HOLD_RESET;
      end
    end else if (do_write) begin
      if (page_one) begin
        if (word_addr == `MIC_BIAS_CONTROL_IDX) begin
          mic_bias_reg <= pwdata[1:0];
        end
        for (j = 0; j < 6; j = j + 1) begin
          if (word_addr == (`CM_HOLD_FIRST_IDX + j[7:0])) begin
            cm_hold_reg[j] <= pwdata[1:0];
          end
        end
      end else begin
        case (word_addr)
          `BLOCK_SELECT_IDX: block_sel_reg   <= pwdata[4:0];
          // Both channels may take the same input
          `ROUTE_LEFT_IDX:   route_left_reg  <= pwdata[4:0];
          `ROUTE_RIGHT_IDX:  route_right_reg <= pwdata[4:0];
          `OSR_IDX:          osr_reg         <= pwdata[7:0];
          default:           osr_reg         <= osr_reg;
        endcase
      end
    end
  end

  // Registered outputs toward the analog and filter logic
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      microphone_bias_output <= `MIC_BIAS_OFF;
      common_mode_hold_en    <= 6'h00;
      left_switch_en         <= 4'h0;
      right_switch_en        <= 4'h0;
      filter_type            <= `FILTER_A;
      extra_stage            <= `STAGE_NONE;
      stereo_mode            <= 1'b1;
      route_conflict         <= 1'b0;
      osr_mismatch           <= 1'b0;
    end else begin
      microphone_bias_output <= mic_bias_reg;
      // Hold forced off on inputs routed single-ended, protects the recording
      for (k = 0; k < 6; k = k + 1) begin
        common_mode_hold_en[k] <= cm_hold_reg[k][0] &&
          !((k % 3 == 0) ? (route_left_reg[0] | route_right_reg[0]) :
            (route_left_reg[1] | route_right_reg[1]));
      end
      // Conflicting routing is not applied to the switches
      left_switch_en  <= conflict_now ? 4'h0 : route_left_reg[3:0];
      right_switch_en <= conflict_now ? 4'h0 : route_right_reg[3:0];
      // Filter type follows the block; illegal keeps block one
      // IIR always present, only extra stage varies
      filter_type    <= dec_valid ? dec_filter : `FILTER_A;
      extra_stage    <= dec_valid ? dec_stage : `STAGE_NONE;
      stereo_mode    <= dec_valid ? dec_stereo : 1'b1;
      route_conflict <= conflict_now;
      osr_mismatch   <= dec_valid && !dec_osr_ok;
    end
  end

endmodule

/* route_props.sv */
// Port-level checks for the ADC route block
`timescale 1ns/1ps
module route_props (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic        pready,
  input logic        pslverr,
  input logic [1:0]  microphone_bias_output,
  input logic [3:0]  left_switch_en,
  input logic [3:0]  right_switch_en,
  input logic [1:0]  filter_type,
  input logic [1:0]  extra_stage,
  input logic        stereo_mode,
  input logic        route_conflict
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Completed write to the bias register
  wire bias_wr = psel && penable && pready && pwrite && paddr == 12'h4CC;
  setup_answer_a: assert property (psel && !penable |=> pready && penable)
    else $error("setup not answered next cycle");
  answer_phase_a: assert property (pready |-> psel && penable)
    else $error("answer outside access phase");
  error_answer_a: assert property (pslverr |-> pready)
    else $error("error without answer");
  // Register lands at the write edge, output one edge later
  bias_write_a: assert property (bias_wr |-> ##2 microphone_bias_output == $past(pwdata[1:0], 2))
    else $error("bias output not written value");
  conflict_off_a: assert property (route_conflict |-> left_switch_en == 4'h0 && right_switch_en == 4'h0)
    else $error("switches on during conflict");
  stage_code_a: assert property (filter_type != 2'h3 && extra_stage != 2'h3)
    else $error("illegal filter or stage code");
  mono_c_a: assert property (filter_type == 2'h2 && extra_stage == 2'h0 |-> !stereo_mode)
    else $error("plain filter C block not mono");
  reset_val_a: assert property ($rose(presetn) |-> microphone_bias_output == 2'h3 && filter_type == 2'h0 && stereo_mode && left_switch_en == 4'h0)
    else $error("outputs not at reset state");
  cover property (route_conflict);
  cover property (bias_wr);
  cover property (pslverr);
endmodule
bind adc_input_route_and_block_select route_props u_props (.*);

/* apb_host.sv */
// Host-side APB master model for the ADC route block
`timescale 1ns/1ps
module apb_host (
  input  logic        pclk,
  output logic        psel,
  output logic        penable,
  output logic        pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input  logic [31:0] prdata,
  input  logic        pready,
  input  logic        pslverr
);
  // Idle bus from time zero
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  // One transfer; pready, data and error taken at the rising edge
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
            output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Hold the request until pready is seen at a rising edge
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

/* tb.sv */
// Self-checking bench for the ADC route block
`timescale 1ns/1ps
module tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, err, stereo, conflict, mism;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  bias, ftype, stage;
  logic [5:0]  hold;
  logic [3:0]  lsw, rsw;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  // 250 MHz clock
  always #2 pclk = ~pclk;
  apb_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  adc_input_route_and_block_select dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .microphone_bias_output(bias),
    .common_mode_hold_en(hold), .left_switch_en(lsw), .right_switch_en(rsw),
    .filter_type(ftype), .extra_stage(stage), .stereo_mode(stereo),
    .route_conflict(conflict), .osr_mismatch(mism));
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  task close_out;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Write, then let the one-clock output lag land
  task wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rd, err);
    @(posedge pclk);
    #1;
  endtask
  task rdc(input string n, input logic [11:0] a, input logic [31:0] e);
    host.xfer(1'b0, a, 32'h0, rd, err);
    chk(n, rd, e);
  endtask
  task t_reset;
    chk("hold", hold, 32'h0);
    chk("sw", {lsw, rsw}, 32'h0);
    chk("blk", {ftype, stage, stereo}, 32'h1);
    rdc("sel", 12'h0F4, 32'h1);
  endtask
  task t_bias;
    for (int i = 0; i < 4; i++) begin
      wr(12'h4CC, i);
      chk("bias", bias, i);
      rdc("biasr", 12'h4CC, i);
    end
  endtask
  task t_blocks;
    logic [31:0] f, s, st;
    for (int b = 1; b <= 18; b++) begin
      f = (b - 1) / 6;
      s = (b - 1) % 3;
      st = (b <= 3 || (b >= 7 && b <= 9) || b == 14 || b == 15);
      wr(12'h0F4, b);
      if (b == 1) chk("mism0", mism, 32'h0);
      chk("ftype", ftype, f);
      chk("stage", stage, s);
      chk("stereo", stereo, st);
      rdc("info", 12'h108, 32'h40 | st << 5 | s << 3 | f);
    end
    // ratio 128 left over, then the 32 the block needs
    chk("mism", mism, 32'h1);
    wr(12'h110, 32'h20);
    chk("mism", mism, 32'h0);
  endtask
  task t_route;
    wr(12'h100, 32'h8);
    wr(12'h104, 32'h4);
    chk("sw", {lsw, rsw}, 32'h84);
    wr(12'h104, 32'h8);
    wr(12'h100, 32'h1);
    chk("conf", conflict, 32'h1);
    chk("swoff", {lsw, rsw}, 32'h0);
    rdc("stat", 12'h10C, 32'h1);
    wr(12'h100, 32'h0);
    wr(12'h104, 32'h0);
    wr(12'h4D0, 32'h1);
    chk("hold", hold, 32'h1);
    rdc("holdr", 12'h4D0, 32'h1);
  endtask
  task t_err;
    host.xfer(1'b0, 12'hFFC, 32'h0, rd, err);
    chk("slverr", err, 32'h1);
    chk("rdz", rd, 32'h0);
    wr(12'h108, 32'h0);
    rdc("info", 12'h108, 32'h52);
  endtask
  // Hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      close_out;
    end
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    t_reset;
    t_bias;
    t_blocks;
    t_route;
    t_err;
    close_out;
  end
endmodule
